// *** bmc_top.sv ***
// buck mode control: mode decode, current limit debounce, voltage settings
`timescale 1ns/100ps

module bmc_top #(
  parameter int unsigned N_REG        = 2,
  parameter int unsigned DEBOUNCE_CYC = bmc_pkg::DEBOUNCE_CYC
) (
  input  wire logic                             i_core_clk,
  input  wire logic                             i_rst,
  input  wire bmc_pkg::bmc_pstate_t             i_power_state,
  input  wire bmc_pkg::bmc_ctrl_t [N_REG-1:0]   i_ctrl,
  input  wire logic [N_REG-1:0]                 i_fused_scaling_disable,
  input  wire logic [N_REG-1:0][5:0]            i_fused_voltage_code,
  input  wire logic                             i_processor_reset_out,
  input  wire logic [N_REG-1:0]                 i_volt_wr,
  input  wire bmc_pkg::bmc_volt_t [N_REG-1:0]   i_volt_wdata,
  input  wire logic [N_REG-1:0]                 i_hs_limit,
  input  wire logic [N_REG-1:0]                 i_ls_limit,
  output bmc_pkg::bmc_drive_t [N_REG-1:0]       o_drive,
  output logic [N_REG-1:0]                      o_hs_gate_off,
  output logic [N_REG-1:0]                      o_ls_gate_off,
  output logic [N_REG-1:0]                      o_hs_limit_sense,
  output logic [N_REG-1:0]                      o_ls_limit_sense,
  output logic [N_REG-1:0]                      o_hs_limit_status,
  output logic [N_REG-1:0]                      o_ls_limit_status,
  output bmc_pkg::bmc_volt_t [N_REG-1:0]        o_volt
);

  localparam int unsigned CNT_W = $clog2(DEBOUNCE_CYC + 2);
  localparam logic [CNT_W-1:0] CNT_LIMIT = CNT_W'(DEBOUNCE_CYC);

  // ==========================================================
  // limit input synchronisers (pins from the analog stage)
  logic [N_REG-1:0] hs_meta;
  logic [N_REG-1:0] hs_sync;
  logic [N_REG-1:0] ls_meta;
  logic [N_REG-1:0] ls_sync;

  // two flops per limit input
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hs_meta <= '0;
      hs_sync <= '0;
      ls_meta <= '0;
      ls_sync <= '0;
    end else begin
      hs_meta <= i_hs_limit;
      hs_sync <= hs_meta;
      ls_meta <= i_ls_limit;
      ls_sync <= ls_meta;
    end
  end

  // ==========================================================
  // startup detection: going from the regulators-off state to run
  bmc_pkg::bmc_pstate_t prev_state;
  bmc_pkg::bmc_pstate_t next_prev_state;
  logic                 startup_load;

  // remember last power state to spot off to run
  always_comb begin
    next_prev_state = i_power_state;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_state <= bmc_pkg::BMC_PS_OFF;
    end else begin
      prev_state <= next_prev_state;
    end
  end

  assign startup_load = (prev_state == bmc_pkg::BMC_PS_OFF) &&
                        (i_power_state == bmc_pkg::BMC_PS_RUN);

  // ==========================================================
  // per-regulator logic
  genvar g;
  generate
    for (g = 0; g < N_REG; g++) begin : g_reg
      bmc_pkg::bmc_drive_t next_drive;
      bmc_pkg::bmc_volt_t  next_volt;
      logic                next_hs_off;
      logic                next_ls_off;
      logic                next_hs_sense;
      logic                next_ls_sense;
      logic                next_hs_status;
      logic                next_ls_status;
      logic [CNT_W-1:0]    hs_cnt;
      logic [CNT_W-1:0]    ls_cnt;
      logic [CNT_W-1:0]    next_hs_cnt;
      logic [CNT_W-1:0]    next_ls_cnt;

      // mode decode from power state and control bits
      always_comb begin
        logic active;
        logic in_low_state;
        active       = 1'b0;
        in_low_state = 1'b0;
        case (i_power_state)
          bmc_pkg::BMC_PS_RUN: begin
            active = i_ctrl[g].regulator_enable;
          end
          bmc_pkg::BMC_PS_STANDBY: begin
            active       = i_ctrl[g].regulator_enable & i_ctrl[g].standby_enable;
            in_low_state = 1'b1;
          end
          bmc_pkg::BMC_PS_SLEEP: begin
            active       = i_ctrl[g].regulator_enable & i_ctrl[g].sleep_enable;
            in_low_state = 1'b1;
          end
          default: begin
            active = 1'b0;
          end
        endcase
        next_drive = '0;
        // fused select steers the reference and soft start, never the mode
        next_drive.scaling_reference = ~i_fused_scaling_disable[g];
        next_drive.soft_start        = i_fused_scaling_disable[g];
        if (!active) begin
          next_drive.mode         = bmc_pkg::BMC_MODE_OFF;
          next_drive.discharge_on = 1'b1;
        end else if (i_ctrl[g].forced_pwm_select) begin
          next_drive.mode         = bmc_pkg::BMC_MODE_FPWM;
          next_drive.switching_on = 1'b1; // no pulse skip
        end else if (i_ctrl[g].low_power_select && in_low_state) begin
          next_drive.mode               = bmc_pkg::BMC_MODE_LOWPWR;
          next_drive.switching_on       = 1'b1;
          next_drive.pulse_skip_allowed = 1'b1;
          next_drive.low_bias           = 1'b1;
        end else begin
          // run with low power request stays adaptive
          next_drive.mode               = bmc_pkg::BMC_MODE_ADAPTIVE;
          next_drive.switching_on       = 1'b1;
          next_drive.pulse_skip_allowed = 1'b1; // load decides conduction
        end
      end

      // voltage setting registers
      always_comb begin
        next_volt = o_volt[g];
        if (startup_load) begin
          next_volt.run_voltage_code     = i_fused_voltage_code[g];
          next_volt.standby_voltage_code = i_fused_voltage_code[g];
          next_volt.sleep_voltage_code   = i_fused_voltage_code[g];
        end else if (i_volt_wr[g] && !i_fused_scaling_disable[g] &&
                     !i_processor_reset_out) begin
          next_volt = i_volt_wdata[g];
        end
      end

      // current limit: gate off, sense and debounced status
      always_comb begin
        next_hs_off   = hs_sync[g];
        next_ls_off   = ls_sync[g];
        next_hs_sense = hs_sync[g];
        next_ls_sense = ls_sync[g];
        next_hs_cnt   = '0;
        next_ls_cnt   = '0;
        if (hs_sync[g] && hs_cnt <= CNT_LIMIT) begin
          next_hs_cnt = hs_cnt + CNT_W'(1);
        end else if (hs_sync[g]) begin
          next_hs_cnt = hs_cnt;
        end
        if (ls_sync[g] && ls_cnt <= CNT_LIMIT) begin
          next_ls_cnt = ls_cnt + CNT_W'(1);
        end else if (ls_sync[g]) begin
          next_ls_cnt = ls_cnt;
        end
        // sticky once persisted longer than debounce
        next_hs_status = o_hs_limit_status[g] | (hs_cnt > CNT_LIMIT);
        next_ls_status = o_ls_limit_status[g] | (ls_cnt > CNT_LIMIT);
      end

      // register everything
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          o_drive[g]           <= '0;
          o_volt[g]            <= {bmc_pkg::VOLT_RST, bmc_pkg::VOLT_RST, bmc_pkg::VOLT_RST};
          o_hs_gate_off[g]     <= 1'b0;
          o_ls_gate_off[g]     <= 1'b0;
          o_hs_limit_sense[g]  <= 1'b0;
          o_ls_limit_sense[g]  <= 1'b0;
          o_hs_limit_status[g] <= 1'b0;
          o_ls_limit_status[g] <= 1'b0;
          hs_cnt               <= '0;
          ls_cnt               <= '0;
        end else begin
          o_drive[g]           <= next_drive;
          o_volt[g]            <= next_volt;
          o_hs_gate_off[g]     <= next_hs_off;
          o_ls_gate_off[g]     <= next_ls_off;
          o_hs_limit_sense[g]  <= next_hs_sense;
          o_ls_limit_sense[g]  <= next_ls_sense;
          o_hs_limit_status[g] <= next_hs_status;
          o_ls_limit_status[g] <= next_ls_status;
          hs_cnt               <= next_hs_cnt;
          ls_cnt               <= next_ls_cnt;
        end
      end
    end
  endgenerate

endmodule

// *** bmc_pkg.sv ***
// package: shared constants and types for the buck mode control block
package bmc_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned DEBOUNCE_US    = 8_000;      // 8.0 ms
  localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;

  // ==========================================================
  // widths and reset values
  localparam int unsigned VOLT_W         = 6;
  localparam logic [5:0]  VOLT_RST       = 6'h00;

  // ==========================================================
  // power states and regulator modes
  typedef enum logic [1:0] {
    BMC_PS_OFF,
    BMC_PS_RUN,
    BMC_PS_STANDBY,
    BMC_PS_SLEEP
  } bmc_pstate_t;

  typedef enum logic [1:0] {
    BMC_MODE_OFF,
    BMC_MODE_ADAPTIVE,
    BMC_MODE_FPWM,
    BMC_MODE_LOWPWR
  } bmc_mode_t;

  // per-regulator control bits
  typedef struct packed {
    logic regulator_enable;
    logic standby_enable;
    logic sleep_enable;
    logic low_power_select;
    logic forced_pwm_select;
  } bmc_ctrl_t;

  // per-regulator drive to the power stage
  typedef struct packed {
    bmc_mode_t mode;
    logic      switching_on;
    logic      discharge_on;
    logic      pulse_skip_allowed;
    logic      low_bias;
    logic      scaling_reference;
    logic      soft_start;
  } bmc_drive_t;

  // per-regulator voltage setting registers
  typedef struct packed {
    logic [5:0] run_voltage_code;
    logic [5:0] standby_voltage_code;
    logic [5:0] sleep_voltage_code;
  } bmc_volt_t;

endpackage

// *** bmc_stage_model.sv ***
// power stage stand-in: current-limit comparators
`timescale 1ns/100ps
module bmc_stage_model (
  input  wire logic [1:0] i_hs_req,
  input  wire logic [1:0] i_ls_req,
  output wire logic [1:0] o_hs_limit,
  output wire logic [1:0] o_ls_limit
);
  // comparators trip a few ns after the load step, off the clock
  assign #7 o_hs_limit = i_hs_req;
  assign #7 o_ls_limit = i_ls_req;
endmodule

// *** bmc_checker.sv ***
// assertions on the ports of the buck mode control top
`timescale 1ns/100ps
module bmc_checker #(
  parameter int unsigned N_REG        = 2,
  parameter int unsigned DEBOUNCE_CYC = 10
) (
  input wire logic                            i_core_clk,
  input wire logic                            i_rst,
  input wire bmc_pkg::bmc_pstate_t            i_power_state,
  input wire bmc_pkg::bmc_ctrl_t [N_REG-1:0]  i_ctrl,
  input wire logic [N_REG-1:0]                i_fused_scaling_disable,
  input wire logic [N_REG-1:0][5:0]           i_fused_voltage_code,
  input wire logic [N_REG-1:0]                i_hs_limit,
  input wire bmc_pkg::bmc_drive_t [N_REG-1:0] o_drive,
  input wire logic [N_REG-1:0]                o_hs_limit_sense,
  input wire logic [N_REG-1:0]                o_hs_limit_status,
  input wire bmc_pkg::bmc_volt_t [N_REG-1:0]  o_volt
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ctrl bits: 4 enable, 3 standby, 2 sleep, 1 low power, 0 forced pwm
  a_disable_off: assert property (!i_ctrl[0][4] |=> o_drive[0].mode == 2'h0 &&
    o_drive[0].discharge_on && !o_drive[0].switching_on) else $error("not off");
  a_fpwm_wins: assert property (i_ctrl[0][4] && i_ctrl[0][0] && i_power_state == 2'h1 |=>
    o_drive[0].mode == 2'h2 && !o_drive[0].pulse_skip_allowed) else $error("no fpwm");
  a_run_not_low: assert property (i_power_state == 2'h1 |=> o_drive[0].mode != 2'h3)
    else $error("low power in run");
  a_low_entry: assert property (i_power_state == 2'h2 && i_ctrl[0] == 5'h1a |=>
    o_drive[0].mode == 2'h3 && o_drive[0].low_bias) else $error("no low power");
  a_limit_follow: assert property ($changed(i_hs_limit[0]) |-> ##3
    o_hs_limit_sense[0] == $past(i_hs_limit[0], 3)) else $error("sense late");
  a_status_wait: assert property ($rose(o_hs_limit_status[0]) |->
    $past(o_hs_limit_sense[0]) && $past(o_hs_limit_sense[0], DEBOUNCE_CYC)) else $error("early");
  a_start_load: assert property ($past(i_power_state) == 2'h0 && i_power_state == 2'h1 |=>
    o_volt[0] == {3{$past(i_fused_voltage_code[0])}}) else $error("no load");
  a_ro_hold: assert property (i_fused_scaling_disable[0] && $past(i_power_state) != 2'h0 |=>
    $stable(o_volt[0])) else $error("read-only changed");
  c_low: cover property (o_drive[0].mode == 2'h3);
  c_status: cover property ($rose(o_hs_limit_status[0]));
  c_load: cover property ($past(i_power_state) == 2'h0 && i_power_state == 2'h1);
endmodule
bind bmc_top bmc_checker #(.N_REG(N_REG), .DEBOUNCE_CYC(DEBOUNCE_CYC)) i_chk (.*);

// *** bmc_top_tb.sv ***
// self-checking bench for the buck mode control top
`timescale 1ns/100ps
`define CHK(t, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", t, e, g); end end
module bmc_top_tb;
  localparam int unsigned DEB = 10;
  logic                      i_core_clk = 1'b0, i_rst = 1'b1, i_processor_reset_out = 1'b1;
  bmc_pkg::bmc_pstate_t      i_power_state = bmc_pkg::BMC_PS_OFF;
  bmc_pkg::bmc_ctrl_t [1:0]  i_ctrl = '0;
  logic [1:0]                i_fused_scaling_disable = '0, i_volt_wr = '0, i_hs_limit, i_ls_limit;
  logic [1:0]                o_hs_gate_off, o_ls_gate_off, o_hs_limit_sense, o_ls_limit_sense;
  logic [1:0]                o_hs_limit_status, o_ls_limit_status;
  logic [1:0][5:0]           i_fused_voltage_code = '0;
  bmc_pkg::bmc_volt_t [1:0]  i_volt_wdata = '0, o_volt;
  bmc_pkg::bmc_drive_t [1:0] o_drive;
  logic [3:0]                lim = '0;
  int                        bad_count = 0, n_tests = 0;
  bmc_top #(.DEBOUNCE_CYC(DEB)) i_dut (.*);
  bmc_stage_model i_stage (.i_hs_req(lim[1:0]), .i_ls_req(lim[3:2]), .o_hs_limit(i_hs_limit),
    .o_ls_limit(i_ls_limit));
  // 25 MHz core clock
  always #20 i_core_clk = ~i_core_clk;
  // wait n rising edges, then let them settle
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask
  // expected mode code: 0 off, 1 adaptive, 2 forced pwm, 3 low power
  function automatic logic [1:0] f_mode(input int s, input logic [4:0] c);
    if (s == 0 || !c[4] || (s == 2 && !c[3]) || (s == 3 && !c[2])) return 2'h0;
    return c[0] ? 2'h2 : (c[1] && s > 1) ? 2'h3 : 2'h1;
  endfunction
  // every power state and control word, fused select both ways
  task automatic t_modes;
    for (int k = 0; k < 256; k++) begin
      i_power_state = bmc_pkg::bmc_pstate_t'(k[7:6]);
      i_ctrl = {~k[4:0], k[4:0]};
      i_fused_scaling_disable = {k[5], ~k[5]};
      step(1);
      `CHK("mode0", f_mode(k[7:6], k[4:0]), o_drive[0].mode)
      `CHK("mode1", f_mode(k[7:6], ~k[4:0]), o_drive[1].mode)
      `CHK("soft1", k[5], o_drive[1].soft_start)
      `CHK("ref0", k[5], o_drive[0].scaling_reference)
    end
  endtask
  // startup load, then host writes with regulator 1 read-only
  task automatic t_volt;
    i_power_state = bmc_pkg::BMC_PS_OFF;
    i_fused_voltage_code = {6'h15, 6'h2a};
    step(1);
    i_power_state = bmc_pkg::BMC_PS_RUN;
    i_volt_wr = 2'h1; // regulator 1 is read-only, host never writes it
    step(1);
    `CHK("load", {{3{6'h15}}, {3{6'h2a}}}, o_volt)
    i_processor_reset_out = 1'b0;
    i_volt_wdata = {18'h0f0f0, 18'h30c3a};
    step(2);
    i_volt_wr = '0;
    `CHK("write", {{3{6'h15}}, 18'h30c3a}, o_volt)
  endtask
  // two faults of exactly the debounce length, then a longer one
  task automatic t_limit(input int b, input logic [3:0] prior);
    for (int r = 0; r < 3; r++) begin
      lim[b] = 1'b1;
      step(r < 2 ? DEB : DEB + 8);
      `CHK("sense", {2{4'h1 << b}}, {o_ls_gate_off, o_hs_gate_off, o_ls_limit_sense,
        o_hs_limit_sense})
      `CHK("status", prior | (r == 2) << b, {o_ls_limit_status, o_hs_limit_status})
      lim[b] = 1'b0;
      step(4);
    end
  endtask
  // counts, verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    step(3);
    i_rst = 1'b0;
    step(1);
    t_modes();
    t_volt();
    t_limit(0, 4'h0);
    t_limit(3, 4'h1);
    results();
  end
  // watchdog: the scenarios need well under 1000 cycles
  initial begin
    #40000;
    bad_count++;
    results();
  end
endmodule
